// ### burner_safety_defines.vh
`ifndef BURNER_SAFETY_DEFINES_VH
`define BURNER_SAFETY_DEFINES_VH
// sequence phases driven by the sequencer
`define PH_INITIATE   4'h0
`define PH_STANDBY    4'h1
`define PH_PREPURGE   4'h2
`define PH_PREIGN     4'h3
`define PH_PILOT      4'h4
`define PH_MAIN       4'h5
`define PH_RUN        4'h6
`define PH_POSTPURGE  4'h7
// lockout cause codes, zero means none
`define C_NONE        5'h00
`define C_AC_ERR      5'h01
`define C_INIT_TIME   5'h02
`define C_STBY_FLAME  5'h03
`define C_STBY_PII    5'h04
`define C_ILK_WELD    5'h05
`define C_PILOT_FB    5'h06
`define C_MAIN_FB     5'h07
`define C_INTERNAL    5'h08
`define C_PII_OPEN    5'h09
`define C_PURGE_FLAME 5'h0a
`define C_RATE_PROOF  5'h0b
`define C_LILK_LATE   5'h0c
`define C_LILK_OPEN   5'h0d
`define C_IAS_ILK     5'h0e
`define C_LOW_FIRE    5'h0f
`define C_PILOT_OFF   5'h10
`define C_MAIN_OFF    5'h11
`define C_NO_FLAME    5'h12
`define C_POST_PII    5'h13
`define C_POST_FLAME  5'h14
`define C_SENSOR      5'h15
`define C_AC_PERSIST  5'h16
// timing, seconds
`define CLK_HZ        100000000
`define T_INIT_S      9'd240
`define T_STBY_FLAME  9'd240
`define T_STBY_PII    9'd30
`define T_ILK_WELD    9'd120
`define T_PURGE_FLAME 9'd10
`define T_RATE_PROOF  9'd255
`define T_LILK_CLOSE  9'd10
`define T_POST_PII    9'd5
`define T_POST_FLAME  9'd240
`define T_AC_PERSIST  9'd240
`define SEC_PER_MIN   16'h003c
// apb byte offsets
`define A_CONTROL     8'h00
`define A_CONFIG      8'h04
`define A_ALERT_MASK  8'h08
`define A_STATUS      8'h0c
`define A_LOCK_HIST   8'h10
`define A_ALERT_HIST  8'h40
// config bit positions
`define CF_ILK_CHECK  0
`define CF_LILK_PROG  1
`define CF_IAS_EN     2
`define CF_LFP_EN     3
`define CF_INT_PILOT  4
`define CF_FLAME_LOCK 5
`define CF_MIN_LSB    16
`define CF_MIN_MSB    25
`define ALERT_DEPTH   15
`endif

// ### burner_safety_lockout_monitor.v
`timescale 1ns/1ps
`include "burner_safety_defines.vh"
// Summary of operation
// - lockout shuts down, latches until reset request, logged in history
// - other faults are alert pulses; alarm closure chosen per code
// - fifteen-deep alert history, one entry per code, newest kept
// - lockout alarm holds until cleared; alert alarm mutable to 600 minutes
// - initiate locks out on line power error or past four minutes
// - standby locks out on flame after 240 seconds
// - standby locks out after 30 s accumulated open preignition interlock
// - start check on: string closed 120 s with controller closed locks out
// - energized valve feedback in idle phases and internal faults outside initiate and pre-ignition lock out
// - prepurge locks out when preignition or lockout interlock opens
// - prepurge locks out after 10 s accumulated flame
// - prepurge locks out when rate proof is missing 255 s after rate command
// - programmed lockout interlock open 10 s into prepurge locks out
// - pre-ignition locks out on interlock opens, interrupted air too
// - pilot period checks proof, interlock, valves and final flame
// - main period checks proof, interlock, both valves and final flame
// - run checks flame loss, interlocks, interrupted pilot, main valve
// - postpurge locks out on interlock open after 5 s or 240 s flame
// - run flame loss drops fuel at once, lockout after postpurge
// - interlock or safety sensor fault locks out, drops blower; firing defers
// - last retry without pilot flame drops pilot, igniter, then postpurge
// - only button, remote input or display command clear; power keeps lockout
// - line supply fault over 240 seconds locks out
module burner_safety_lockout_monitor #(
    parameter TICK_CYCLES = `CLK_HZ
) (
    input  wire        clock, // system clock
    input  wire        srst, // sync reset
    input  wire        psel, // apb select
    input  wire        penable, // apb enable
    input  wire        pwrite, // apb direction
    input  wire [7:0]  paddr, // apb byte address
    input  wire [31:0] pwdata, // apb write data
    output reg  [31:0] prdata, // apb read data
    output reg         pready, // apb ready
    output reg         pslverr, // apb error, unmapped
    input  wire [3:0]  phase, // sequence phase
    input  wire        flame, // flame present
    input  wire        preignitionClosed, // preignition_interlock closed
    input  wire        lockoutIlkClosed, // lockout interlock closed
    input  wire        interlockClosed, // interlock_string closed
    input  wire        controllerClosed, // load_limit_input closed
    input  wire        pilotValveFb, // pilot terminal energized
    input  wire        mainValveFb, // main terminal energized
    input  wire        highFireProof, // high_fire_proof
    input  wire        lowFireProof, // low_fire_proof
    input  wire        rateCmdHigh, // pulse, high fire command
    input  wire        rateCmdLow, // pulse, low fire command
    input  wire        periodEnd, // pulse, period end
    input  wire        lastRetry, // final retry
    input  wire        postpurgeDone, // pulse, postpurge done
    input  wire        acLineError, // line power error
    input  wire        internalFault, // internal fault
    input  wire        safetySensorBad, // safety sensor defective
    input  wire        lockoutRetained, // stored lockout, read in reset
    input  wire        resetButton, // pulse, pushbutton
    input  wire        remoteResetInput, // pulse, remote_reset_input
    input  wire        alertEvent, // pulse, alert entered
    input  wire [3:0]  alertCode, // alert code
    output reg         lockout, // latched lockout
    output reg  [4:0]  lockoutCause, // lockout cause
    output reg         alarm, // alarm contact
    output reg         fuelDrop, // fuel valves off
    output reg         igniterDrop, // igniter off
    output reg         blowerDrop, // blower off
    output reg         alertPulse // alert event out
);

////////////////////////////////////////////////////////////////////////////////
function [8:0] sat9;
    input [8:0] v;
    begin
        sat9 = (v == 9'h1ff) ? v : v + 9'h001;
    end
endfunction

function [3:0] findCode;
    input [59:0] codes;
    input [14:0] valid;
    input [3:0]  code;
    integer      k;
    begin
        findCode = 4'he;
        for (k = `ALERT_DEPTH - 1; k >= 0; k = k - 1) begin
            if (valid[k] && codes[k*4 +: 4] == code) begin
                findCode = k[3:0];
            end
        end
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
reg  [26:0] tickCnt_q;
wire        secTick = (tickCnt_q == TICK_CYCLES - 1);
reg  [3:0]  prevPhase_q;
wire        phaseNew = (phase != prevPhase_q);
reg  [8:0]  phaseSec_q;
reg  [8:0]  piiOpenSec_q;
reg  [8:0]  ilkClosedSec_q;
reg  [8:0]  flameSec_q;
reg  [8:0]  acSec_q;
reg  [8:0]  proofSec_q;
reg         proofRun_q;
reg         proofHigh_q;
reg         lilkSeen_q;
reg         pending_q;
reg  [4:0]  pendCause_q;
reg  [5:0]  cfg_q;
reg  [9:0]  silenceMin_q;
reg  [15:0] alertMask_q;
reg         alertAlarm_q;
reg  [15:0] muteSec_q;
reg  [19:0] lockHist_q;
reg  [7:0]  lockCount_q;
reg  [59:0] histCode_q;
reg  [14:0] histValid_q;

always @(posedge clock) begin
    if (srst || secTick) begin
        tickCnt_q <= 27'h0000000;
    end else begin
        tickCnt_q <= tickCnt_q + 27'h0000001;
    end
end

// timers and accumulators, all on the one-second tick
always @(posedge clock) begin
    if (srst) begin
        prevPhase_q    <= `PH_INITIATE;
        phaseSec_q     <= 9'h000;
        piiOpenSec_q   <= 9'h000;
        ilkClosedSec_q <= 9'h000;
        flameSec_q     <= 9'h000;
        acSec_q        <= 9'h000;
        lilkSeen_q     <= 1'b0;
    end else begin
        prevPhase_q <= phase;
        if (phaseNew) begin
            phaseSec_q     <= 9'h000;
            piiOpenSec_q   <= 9'h000;
            ilkClosedSec_q <= 9'h000;
            lilkSeen_q     <= 1'b0;
            // flame from run carries into postpurge accumulation
            if (phase != `PH_POSTPURGE) begin
                flameSec_q <= 9'h000;
            end
        end else begin
            if (lockoutIlkClosed) begin
                lilkSeen_q <= 1'b1;
            end
            if (secTick) begin
                phaseSec_q <= sat9(phaseSec_q);
                if (!preignitionClosed) begin
                    piiOpenSec_q <= sat9(piiOpenSec_q);
                end
                // a jumper shows as a string that never opens
                if (interlockClosed && controllerClosed) begin
                    ilkClosedSec_q <= sat9(ilkClosedSec_q);
                end else begin
                    ilkClosedSec_q <= 9'h000;
                end
                if (flame) begin
                    flameSec_q <= sat9(flameSec_q);
                end
            end
        end
        if (!acLineError) begin
            acSec_q <= 9'h000;
        end else if (secTick) begin
            acSec_q <= sat9(acSec_q);
        end
    end
end

// rate proof watchdog, started by the actuator command
always @(posedge clock) begin
    if (srst || lockout) begin
        proofRun_q  <= 1'b0;
        proofHigh_q <= 1'b0;
        proofSec_q  <= 9'h000;
    end else if (rateCmdHigh || rateCmdLow) begin
        proofRun_q  <= 1'b1;
        proofHigh_q <= rateCmdHigh;
        proofSec_q  <= 9'h000;
    end else if (proofRun_q) begin
        if (proofHigh_q ? highFireProof : lowFireProof) begin
            proofRun_q <= 1'b0;
        end else if (secTick) begin
            proofSec_q <= sat9(proofSec_q);
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
reg  [4:0] cause;
wire       firing = (phase == `PH_PILOT) || (phase == `PH_MAIN) || (phase == `PH_RUN);
wire       lilkOpen = cfg_q[`CF_LILK_PROG] && !lockoutIlkClosed;

always @* begin
    cause = `C_NONE;
    case (phase)
        `PH_INITIATE: begin
            if (acLineError) cause = `C_AC_ERR;
            else if (phaseSec_q > `T_INIT_S) cause = `C_INIT_TIME;
        end
        `PH_STANDBY: begin
            if (flame && phaseSec_q >= `T_STBY_FLAME) cause = `C_STBY_FLAME;
            else if (piiOpenSec_q >= `T_STBY_PII) cause = `C_STBY_PII;
            else if (cfg_q[`CF_ILK_CHECK] && ilkClosedSec_q >= `T_ILK_WELD)
                cause = `C_ILK_WELD;
        end
        `PH_PREPURGE: begin
            if (!preignitionClosed) cause = `C_PII_OPEN;
            else if (lilkOpen && lilkSeen_q) cause = `C_LILK_OPEN;
            else if (flameSec_q >= `T_PURGE_FLAME) cause = `C_PURGE_FLAME;
            else if (lilkOpen && phaseSec_q >= `T_LILK_CLOSE) cause = `C_LILK_LATE;
            else if (proofRun_q && proofSec_q >= `T_RATE_PROOF) cause = `C_RATE_PROOF;
        end
        `PH_PREIGN: begin
            if (lilkOpen) cause = `C_LILK_OPEN;
            else if (cfg_q[`CF_IAS_EN] && !interlockClosed) cause = `C_IAS_ILK;
            else if (!preignitionClosed) cause = `C_PII_OPEN;
        end
        `PH_PILOT: begin
            if (cfg_q[`CF_LFP_EN] && !lowFireProof) cause = `C_LOW_FIRE;
            else if (lilkOpen) cause = `C_LILK_OPEN;
            else if (!pilotValveFb) cause = `C_PILOT_OFF;
            else if (mainValveFb) cause = `C_MAIN_FB;
            else if (periodEnd && !flame && lastRetry) cause = `C_NO_FLAME;
        end
        `PH_MAIN: begin
            if (cfg_q[`CF_LFP_EN] && !lowFireProof) cause = `C_LOW_FIRE;
            else if (lilkOpen) cause = `C_LILK_OPEN;
            else if (!pilotValveFb) cause = `C_PILOT_OFF;
            else if (!mainValveFb) cause = `C_MAIN_OFF;
            else if (periodEnd && !flame) cause = `C_NO_FLAME;
        end
        `PH_RUN: begin
            if (!flame && cfg_q[`CF_FLAME_LOCK]) cause = `C_NO_FLAME;
            else if (lilkOpen) cause = `C_LILK_OPEN;
            else if (cfg_q[`CF_IAS_EN] && !interlockClosed) cause = `C_IAS_ILK;
            else if (cfg_q[`CF_INT_PILOT] && pilotValveFb) cause = `C_PILOT_FB;
            else if (!mainValveFb) cause = `C_MAIN_OFF;
        end
        `PH_POSTPURGE: begin
            if (!preignitionClosed && phaseSec_q >= `T_POST_PII) cause = `C_POST_PII;
            else if (flameSec_q >= `T_POST_FLAME) cause = `C_POST_FLAME;
        end
        default: cause = `C_NONE;
    endcase
    // valve feedback in the non-firing phases other than initiate
    if (cause == `C_NONE && !firing && phase != `PH_INITIATE && phase <= `PH_POSTPURGE) begin
        if (pilotValveFb) cause = `C_PILOT_FB;
        else if (mainValveFb) cause = `C_MAIN_FB;
    end
    if (cause == `C_NONE && internalFault && phase != `PH_INITIATE && phase != `PH_PREIGN)
        cause = `C_INTERNAL;
    if (cause == `C_NONE && safetySensorBad) cause = `C_SENSOR;
    if (cause == `C_NONE && acSec_q > `T_AC_PERSIST) cause = `C_AC_PERSIST;
end

////////////////////////////////////////////////////////////////////////////////
wire apbSetup  = psel && !penable;
wire apbAccess = psel && penable && pready;
wire wrCtl     = apbAccess && pwrite && paddr == `A_CONTROL;
wire resetReq  = resetButton || remoteResetInput || (wrCtl && pwdata[0]);
wire newLock   = !lockout && (pending_q ? postpurgeDone : (cause != `C_NONE && !firing));
wire [4:0] newCause = pending_q ? pendCause_q : cause;

// firing faults drop fuel first, latch after postpurge
always @(posedge clock) begin
    if (srst) begin
        lockout      <= lockoutRetained;
        lockoutCause <= `C_NONE;
        pending_q    <= 1'b0;
        pendCause_q  <= `C_NONE;
        lockHist_q   <= 20'h00000;
        lockCount_q  <= 8'h00;
        fuelDrop     <= lockoutRetained;
        igniterDrop  <= lockoutRetained;
        blowerDrop   <= lockoutRetained;
    end else begin
        if (!lockout && !pending_q && firing && cause != `C_NONE) begin
            pending_q   <= 1'b1;
            pendCause_q <= cause;
        end else if (newLock) begin
            pending_q <= 1'b0;
        end
        if (newLock) begin
            lockout      <= 1'b1;
            lockoutCause <= newCause;
            lockHist_q   <= {lockHist_q[14:0], newCause};
            lockCount_q  <= lockCount_q + 8'h01;
        end else if (resetReq) begin
            lockout      <= 1'b0;
            lockoutCause <= `C_NONE;
        end
        fuelDrop    <= lockout || newLock || pending_q || (firing && cause != `C_NONE);
        igniterDrop <= lockout || newLock || pending_q || (firing && cause != `C_NONE);
        blowerDrop  <= lockout || newLock;
    end
end

////////////////////////////////////////////////////////////////////////////////
wire [3:0] hitPos = findCode(histCode_q, histValid_q, alertCode);
wire       alertAlarmSet = alertEvent && alertMask_q[alertCode];
integer    i;

// slot 0 newest, a repeat moves to the front
always @(posedge clock) begin
    if (srst) begin
        histCode_q  <= 60'h0;
        histValid_q <= 15'h0000;
    end else if (alertEvent) begin
        for (i = 1; i < `ALERT_DEPTH; i = i + 1) begin
            if (i <= hitPos) begin
                histCode_q[i*4 +: 4] <= histCode_q[(i-1)*4 +: 4];
                histValid_q[i]       <= histValid_q[i-1];
            end
        end
        histCode_q[3:0] <= alertCode;
        histValid_q[0]  <= 1'b1;
    end
end

// alarm contact: lockouts cannot be muted, alerts can
always @(posedge clock) begin
    if (srst) begin
        alertAlarm_q <= 1'b0;
        muteSec_q    <= 16'h0000;
        alertPulse   <= 1'b0;
        alarm        <= 1'b0;
    end else begin
        alertPulse <= alertEvent;
        if (alertAlarmSet) begin
            alertAlarm_q <= 1'b1;
        end else if (wrCtl && pwdata[1]) begin
            alertAlarm_q <= 1'b0;
        end
        if (wrCtl && pwdata[2]) begin
            muteSec_q <= {6'h00, silenceMin_q} * `SEC_PER_MIN;
        end else if (secTick && muteSec_q != 16'h0000) begin
            muteSec_q <= muteSec_q - 16'h0001;
        end
        alarm <= lockout || newLock || (alertAlarm_q && muteSec_q == 16'h0000);
    end
end

////////////////////////////////////////////////////////////////////////////////
wire       histHit = paddr >= `A_ALERT_HIST && paddr < `A_ALERT_HIST + 8'h3c && paddr[1:0] == 2'h0;
wire [3:0] histIdx = paddr[5:2] - 4'h0;
reg  [31:0] rdMux;
reg         mapped;

always @* begin
    mapped = 1'b1;
    rdMux  = 32'h00000000;
    case (paddr)
        `A_CONTROL:    rdMux = 32'h00000000;
        `A_CONFIG:     rdMux = {6'h00, silenceMin_q, 10'h000, cfg_q};
        `A_ALERT_MASK: rdMux = {16'h0000, alertMask_q};
        `A_STATUS:     rdMux = {11'h000, lockoutCause, 8'h00, 3'h0,
                                muteSec_q != 16'h0000, alertAlarm_q, alarm, pending_q, lockout};
        `A_LOCK_HIST:  rdMux = {lockCount_q, 4'h0, lockHist_q};
        default: begin
            mapped = histHit;
            if (histHit) begin
                rdMux = {27'h0000000, histValid_q[histIdx], histCode_q[histIdx*4 +: 4]};
            end
        end
    endcase
end

// zero wait states: answer loaded at setup
always @(posedge clock) begin
    if (srst) begin
        prdata       <= 32'h00000000;
        pready       <= 1'b0;
        pslverr      <= 1'b0;
        cfg_q        <= 6'h00;
        silenceMin_q <= 10'h000;
        alertMask_q  <= 16'h0000;
    end else begin
        pready  <= apbSetup;
        pslverr <= apbSetup && !mapped;
        prdata  <= (apbSetup && !pwrite && mapped) ? rdMux : 32'h00000000;
        if (apbAccess && pwrite && paddr == `A_CONFIG) begin
            cfg_q <= pwdata[5:0];
            // silence interval is limited to 600 minutes
            silenceMin_q <= (pwdata[`CF_MIN_MSB:`CF_MIN_LSB] > 10'd600) ? 10'd600
                          : pwdata[`CF_MIN_MSB:`CF_MIN_LSB];
        end
        if (apbAccess && pwrite && paddr == `A_ALERT_MASK) begin
            alertMask_q <= pwdata[15:0];
        end
    end
end

endmodule

// ### burner_safety_lockout_monitor_chk.sv
`timescale 1ns/1ps
module burner_safety_lockout_monitor_chk (
    input wire       clock, // clock
    input wire       srst, // reset
    input wire       psel, // apb select
    input wire       penable, // apb enable
    input wire       pready, // apb ready
    input wire       pslverr, // apb error
    input wire [3:0] phase, // phase
    input wire       flame, // flame
    input wire       preignitionClosed, // interlock
    input wire       pilotValveFb, // pilot fb
    input wire       periodEnd, // period end
    input wire       lastRetry, // final retry
    input wire       resetButton, // local reset
    input wire       remoteResetInput, // remote reset
    input wire       lockout, // lockout
    input wire       fuelDrop, // fuel off
    input wire       igniterDrop, // igniter off
    input wire       blowerDrop // blower off
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////////////////////
    a_pready_next: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_pready_once: assert property (pready |=> !pready)
        else $error("ready stood two cycles");
    a_slverr_pair: assert property (pslverr |-> pready)
        else $error("error without ready");
    // display clear comes over apb
    a_lock_hold: assert property (lockout && !resetButton && !remoteResetInput && !psel |=> lockout)
        else $error("lockout dropped unasked");
    a_stby_valve: assert property (phase == 4'h1 && pilotValveFb |=> lockout)
        else $error("energized pilot in standby not locked out");
    a_purge_pii: assert property (phase == 4'h2 && !preignitionClosed |=> lockout)
        else $error("open interlock in prepurge not locked out");
    a_final_try: assert property (phase == 4'h4 && periodEnd && !flame && lastRetry |=> fuelDrop && igniterDrop)
        else $error("pilot and igniter kept after last retry");
    a_drop_lock: assert property ($rose(lockout) |-> blowerDrop && fuelDrop)
        else $error("lockout without blower and fuel drop");
endmodule
bind burner_safety_lockout_monitor burner_safety_lockout_monitor_chk chk_inst (
    .clock(clock), .srst(srst), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .phase(phase),
    .flame(flame), .preignitionClosed(preignitionClosed), .pilotValveFb(pilotValveFb),
    .periodEnd(periodEnd), .lastRetry(lastRetry), .resetButton(resetButton),
    .remoteResetInput(remoteResetInput), .lockout(lockout), .fuelDrop(fuelDrop),
    .igniterDrop(igniterDrop), .blowerDrop(blowerDrop));

// ### field_devices.sv
`timescale 1ns/1ps
module field_devices (
    input  wire       clock,        // system clock
    input  wire       pilotCmd,     // sequencer wants pilot open
    input  wire       fuelDrop,     // safety cuts fuel
    input  wire [1:0] weld,         // stuck contact: pilot, main
    output logic      pilotValveFb, // pilot terminal energized
    output logic      mainValveFb   // main terminal energized
);
    // relay feedback lags one cycle; a welded contact ignores the cut
    always @(posedge clock) begin
        pilotValveFb <= (pilotCmd & !fuelDrop) | weld[0];
        mainValveFb <= weld[1];
    end
endmodule

// ### tb_burner_safety_lockout_monitor.sv
`timescale 1ns/1ps
module tb_burner_safety_lockout_monitor;
    logic        clock, srst, psel, penable, pwrite, pready, pslverr, rerr, flame, highFireProof;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  phase, alertCode;
    logic [6:0]  flt;
    logic        rateCmdHigh, periodEnd, lastRetry, postpurgeDone, resetButton, remoteResetInput;
    logic        alertEvent, pilotCmd, lockoutRetained, pilotValveFb, mainValveFb, lockout;
    logic        alarm, fuelDrop, igniterDrop, blowerDrop, alertPulse;
    logic [4:0]  lockoutCause;
    int          errors = 0;
    int          samples_checked = 0;
    logic [3:0]  phs [8] = '{4'h1, 4'hf, 4'h1, 4'h7, 4'h2, 4'h2, 4'h3, 4'h0};
    int          bits [8] = '{0, 1, 2, 3, 4, 5, 5, 6};
    logic [4:0]  cs [8] = '{5'h08, 5'h15, 5'h06, 5'h07, 5'h09, 5'h0d, 5'h0d, 5'h01};

    burner_safety_lockout_monitor #(.TICK_CYCLES(10)) burner_safety_lockout_monitor_inst (
        .clock(clock), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .phase(phase), .flame(flame), .preignitionClosed(!flt[4]), .lockoutIlkClosed(!flt[5]),
        .interlockClosed(1'b0), .controllerClosed(1'b0), .pilotValveFb(pilotValveFb),
        .mainValveFb(mainValveFb), .highFireProof(highFireProof), .lowFireProof(1'b1),
        .rateCmdHigh(rateCmdHigh), .rateCmdLow(1'b0), .periodEnd(periodEnd),
        .lastRetry(lastRetry), .postpurgeDone(postpurgeDone), .acLineError(flt[6]),
        .internalFault(flt[0]), .safetySensorBad(flt[1]), .lockoutRetained(lockoutRetained),
        .resetButton(resetButton), .remoteResetInput(remoteResetInput),
        .alertEvent(alertEvent), .alertCode(alertCode), .lockout(lockout),
        .lockoutCause(lockoutCause), .alarm(alarm), .fuelDrop(fuelDrop),
        .igniterDrop(igniterDrop), .blowerDrop(blowerDrop), .alertPulse(alertPulse));
    field_devices field_devices_inst (.clock(clock), .pilotCmd(pilotCmd), .fuelDrop(fuelDrop),
        .weld(flt[3:2]), .pilotValveFb(pilotValveFb), .mainValveFb(mainValveFb));

    initial begin
        clock = 0;
        forever #5 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task test_done;
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wait_lock(input logic v, input int lim);
        int n;
        n = 0;
        while (lockout !== v && n < lim) begin
            @(posedge clock);
            #1;
            n++;
        end
        chk(lockout, v);
        if (lockout !== v) test_done();
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clock);
        penable <= 1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        rerr = pslverr;
        if (n >= 20) chk(1, 0);
        psel <= 0;
        penable <= 0;
        #1;
    endtask
    // 0 button, 1 remote input, 2 display command
    task press(input int w);
        if (w == 2) apb(1, 8'h00, 32'h1);
        else begin
            @(posedge clock);
            resetButton <= (w == 0);
            remoteResetInput <= (w == 1);
            @(posedge clock);
            resetButton <= 0;
            remoteResetInput <= 0;
        end
        wait_lock(0, 4);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task fault_case(input int i);
        @(posedge clock);
        phase <= phs[i];
        repeat (2) @(posedge clock);
        flt[bits[i]] <= 1'b1;
        wait_lock(1, 6);
        chk(lockoutCause, cs[i]);
        chk(blowerDrop, 1);
        apb(0, 8'h0c, 0);
        chk(rd, {11'h0, cs[i], 16'h0005});
        flt <= 0;
        phase <= 4'hf;
        repeat (4) @(posedge clock);
        #1 chk(lockout, 1);
        press(i % 3);
    endtask
    task alerts;
        apb(1, 8'h08, 32'h20);
        apb(0, 8'h08, 0);
        chk(rd, 32'h20);
        for (int k = 0; k < 3; k++) begin
            @(posedge clock);
            alertEvent <= 1;
            alertCode <= (k == 1) ? 4'h7 : 4'h5;
            @(posedge clock);
            alertEvent <= 0;
            #1 chk(alertPulse, 1);
        end
        // repeat of 5 replaces its old entry
        for (int k = 0; k < 3; k++) begin
            apb(0, 8'h40 + 8'(4 * k), 0);
            chk(rd, (k == 2) ? 32'h0 : ((k == 0) ? 32'h15 : 32'h17));
        end
        chk(alarm, 1);
        apb(1, 8'h00, 32'h2);
        repeat (3) @(posedge clock);
        #1 chk(alarm, 0);
    endtask
    task rate_proof;
        @(posedge clock);
        phase <= 4'h2;
        @(posedge clock);
        rateCmdHigh <= 1;
        @(posedge clock);
        rateCmdHigh <= 0;
        repeat (2500) @(posedge clock);
        #1 chk(lockout, 0);
        wait_lock(1, 100);
        chk(lockoutCause, 5'h0b);
        highFireProof <= 1;
        phase <= 4'hf;
        press(0);
    endtask
    task pilot_final;
        @(posedge clock);
        pilotCmd <= 1;
        lastRetry <= 1;
        repeat (2) @(posedge clock);
        phase <= 4'h4;
        repeat (3) @(posedge clock);
        periodEnd <= 1;
        @(posedge clock);
        periodEnd <= 0;
        @(posedge clock);
        #1 chk({fuelDrop, igniterDrop, lockout}, 3'b110);
        @(posedge clock);
        phase <= 4'h7;
        pilotCmd <= 0;
        repeat (6) @(posedge clock);
        #1 chk(lockout, 0);
        @(posedge clock);
        postpurgeDone <= 1;
        @(posedge clock);
        postpurgeDone <= 0;
        wait_lock(1, 4);
        chk(lockoutCause, 5'h12);
        phase <= 4'hf;
        press(1);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {psel, penable, pwrite, paddr, pwdata, alertCode, flt, flame, highFireProof} = '0;
        {rateCmdHigh, periodEnd, lastRetry, postpurgeDone, resetButton} = '0;
        {remoteResetInput, alertEvent, pilotCmd, lockoutRetained} = '0;
        phase = 4'hf;
        srst = 1;
        repeat (12) @(posedge clock);
        srst <= 0;
        @(posedge clock);
        #1 chk(lockout, 0);
        apb(0, 8'h80, 0);
        chk(rerr, 1);
        chk(rd, 0);
        // silence time above the limit is clamped
        apb(1, 8'h04, 32'h03ff_0002);
        apb(0, 8'h04, 0);
        chk(rd, 32'h0258_0002);
        for (int i = 0; i < 8; i++) fault_case(i);
        apb(0, 8'h10, 0);
        chk(rd, {8'd8, 4'h0, cs[4], cs[5], cs[6], cs[7]});
        alerts();
        rate_proof();
        pilot_final();
        @(posedge clock);
        lockoutRetained <= 1;
        srst <= 1;
        repeat (2) @(posedge clock);
        srst <= 0;
        @(posedge clock);
        lockoutRetained <= 0;
        #1 chk(lockout, 1);
        test_done();
    end
    initial begin
        repeat (20000) @(posedge clock);
        chk(1, 0);
        test_done();
    end
endmodule
